// ==== pkg/pabmx_pkg.sv ====
// Purpose: Constants for the port A/B alternate-function mux.
// Assumes: AHB-Lite register window, 32-bit words.
// Notes: Offsets are byte addresses.
package pabmx_pkg;
   localparam logic [11:0] PABMX_OFF_PA_AF = 12'h000;
   localparam logic [11:0] PABMX_OFF_PB_AF = 12'h004;
   localparam logic [11:0] PABMX_OFF_PB_SEL1 = 12'h008;
   localparam logic [11:0] PABMX_OFF_PB_SEL2 = 12'h00C;
   localparam logic [11:0] PABMX_OFF_STATUS = 12'h010;
   localparam logic [7:0] PABMX_AF_RESET = 8'h00;
   localparam logic [7:0] PABMX_SEL_RESET = 8'h00;
   localparam logic [1:0] PABMX_PKG_8PIN = 2'h0;
   localparam logic [1:0] PABMX_PKG_20PIN = 2'h1;
   localparam logic [1:0] PABMX_PKG_28PIN = 2'h2;
   localparam int PABMX_STS_DBG_BIT = 0;
   localparam int PABMX_STS_XTAL_BIT = 1;
   localparam int PABMX_STS_PKG_LSB = 2;
   localparam logic [7:0] PABMX_UNLOCK_PATTERN = 8'hA5;
   localparam logic [3:0] PABMX_UNLOCK_LEN = 4'h8;
   localparam logic [1:0] PABMX_HTRANS_NONSEQ = 2'h2;
   localparam logic [31:0] PABMX_ZERO_WORD = 32'h00000000;
   localparam logic [23:0] PABMX_ZERO_PAD = 24'h000000;
endpackage : pabmx_pkg

// ==== verification/pabmx_mux_monitor.sv ====
// Purpose: Port-level assertions for the alternate-function mux.
// Assumes: One clock, hresetn asynchronous active low.
// Notes: Bound into every mux instance.
`timescale 1ns/10ps
module pabmx_mux_chk
   import pabmx_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic [1:0] package_variant,
   input wire logic reset_seq,
   input wire logic xtal_enable,
   input wire logic xtal_pins_en,
   input wire logic [7:0] gpio_a_in,
   input wire logic [7:0] port_a_in,
   input wire logic [7:0] port_b_in,
   input wire logic [7:0] port_b_oe,
   input wire logic [7:0] port_b_analog_en,
   input wire logic external_clock_input,
   input wire logic vref_on_port_b,
   input wire logic debug_enable
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("slave not ready or not okay");
   data_upper_a: assert property (hrdata[31:8] == PABMX_ZERO_PAD)
      else $error("upper read data not zero");
   xtal_over_a: assert property (xtal_enable |-> xtal_pins_en && gpio_a_in[1:0] == 2'h0)
      else $error("crystal pins still reach gpio");
   clk_src_a: assert property (external_clock_input |->
      (package_variant == PABMX_PKG_8PIN ? port_a_in[1] : port_b_in[3]))
      else $error("clock input from wrong pin");
   vref_pkg_a: assert property (vref_on_port_b |-> package_variant == PABMX_PKG_28PIN)
      else $error("reference on port b outside 28-pin");
   reserved_b_a: assert property (port_b_analog_en[7:6] == 2'h0)
      else $error("reserved port b pin routed");
   analog_drive_a: assert property ((port_b_analog_en & port_b_oe) == 8'h00)
      else $error("analog pin also driven");
   unlock_time_a: assert property ($rose(debug_enable) |->
      !reset_seq && ($past(reset_seq) || $past(reset_seq, 2)))
      else $error("debug enabled outside reset check");
   unlock_keep_a: assert property ($fell(debug_enable) |-> reset_seq || $past(reset_seq))
      else $error("debug dropped without reset check");
   cover property ($rose(debug_enable));
   cover property (xtal_enable && xtal_pins_en);
   cover property (vref_on_port_b);
endmodule : pabmx_mux_chk
bind pabmx_mux pabmx_mux_chk u_chk (.hclk, .hresetn, .hreadyout, .hresp, .hrdata,
   .package_variant, .reset_seq, .xtal_enable, .xtal_pins_en, .gpio_a_in, .port_a_in,
   .port_b_in, .port_b_oe, .port_b_analog_en, .external_clock_input, .vref_on_port_b,
   .debug_enable);

// ==== verification/pabmx_pin_model.sv ====
// Purpose: Board-side pin model for ports A and B.
// Assumes: A pin follows the mux while its enable is high, else the board level.
// Notes: The board level is set by the bench and held until the bench changes it.
`timescale 1ns/10ps
module pabmx_pin_model (
   input wire logic [7:0] port_a_out,
   input wire logic [7:0] port_a_oe,
   input wire logic [7:0] port_b_out,
   input wire logic [7:0] port_b_oe,
   input wire logic [7:0] ext_a,
   input wire logic [7:0] ext_b,
   output logic [7:0] port_a_in,
   output logic [7:0] port_b_in
);
   // Per-bit resolution, so a driven pin never reads the board value
   assign port_a_in = (port_a_oe & port_a_out) | (~port_a_oe & ext_a);
   assign port_b_in = (port_b_oe & port_b_out) | (~port_b_oe & ext_b);
endmodule : pabmx_pin_model

// ==== verification/test_port_ab_alternate_function_mux.sv ====
// Purpose: Self-checking bench for the port A/B mux.
// Assumes: Zero-wait AHB-Lite slave, pins resolved by the pin model.
// Notes: Package strap is changed between scenarios and once inside the port B scenario.
`timescale 1ns/10ps
module test_port_ab_alternate_function_mux
   import pabmx_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, reset_seq, xtal_enable;
   logic timer0_in_mode, timer1_in_mode, timer_zero_output, timer_one_output;
   logic uart_driver_enable, uart_transmit_data, timer_zero_input, timer_one_input;
   logic uart_clear_to_send, uart_receive_data, external_clock_input, analog_in0_amp_out;
   logic analog_in1_amp_inv, analog_in2_amp_noninv, analog_in3, analog_in7;
   logic vref_on_port_b, xtal_pins_en, debug_enable;
   logic [1:0] htrans, package_variant;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, d;
   logic [7:0] gpio_a_out, gpio_a_oe, gpio_b_out, gpio_b_oe, port_a_in, port_b_in;
   logic [7:0] port_a_out, port_a_oe, port_b_out, port_b_oe, port_b_analog_en;
   logic [7:0] gpio_a_in, gpio_b_in, ext_a, ext_b;
   int failures, n_compared, cyc;
   assign hready = hreadyout;
   pabmx_mux u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .package_variant(package_variant),
      .reset_seq(reset_seq), .xtal_enable(xtal_enable), .timer0_in_mode(timer0_in_mode),
      .timer1_in_mode(timer1_in_mode), .gpio_a_out(gpio_a_out), .gpio_a_oe(gpio_a_oe),
      .gpio_b_out(gpio_b_out), .gpio_b_oe(gpio_b_oe), .port_a_in(port_a_in),
      .port_b_in(port_b_in), .port_a_out(port_a_out), .port_a_oe(port_a_oe),
      .port_b_out(port_b_out), .port_b_oe(port_b_oe), .port_b_analog_en(port_b_analog_en),
      .gpio_a_in(gpio_a_in), .gpio_b_in(gpio_b_in), .timer_zero_output(timer_zero_output),
      .timer_one_output(timer_one_output), .uart_driver_enable(uart_driver_enable),
      .uart_transmit_data(uart_transmit_data), .timer_zero_input(timer_zero_input),
      .timer_one_input(timer_one_input), .uart_clear_to_send(uart_clear_to_send),
      .uart_receive_data(uart_receive_data), .external_clock_input(external_clock_input),
      .analog_in0_amp_out(analog_in0_amp_out), .analog_in1_amp_inv(analog_in1_amp_inv),
      .analog_in2_amp_noninv(analog_in2_amp_noninv), .analog_in3(analog_in3),
      .analog_in7(analog_in7), .vref_on_port_b(vref_on_port_b), .xtal_pins_en(xtal_pins_en),
      .debug_enable(debug_enable)
   );
   pabmx_pin_model u_pins (
      .port_a_out(port_a_out), .port_a_oe(port_a_oe), .port_b_out(port_b_out),
      .port_b_oe(port_b_oe), .ext_a(ext_a), .ext_b(ext_b), .port_a_in(port_a_in),
      .port_b_in(port_b_in)
   );
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   task automatic report_and_stop;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : report_and_stop
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      // Whole run needs well under a thousand cycles
      if (cyc == 3000) begin
         failures++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("ERROR %0t got %0h expected %0h", $time, g, e);
      end
   endtask : chk
   task automatic phase(input logic [11:0] a, input logic w);
      @(posedge hclk);
      haddr <= {20'h00000, a};
      hwrite <= w;
      htrans <= PABMX_HTRANS_NONSEQ;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
   endtask : phase
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      phase(a, 1'b1);
      hwdata <= {PABMX_ZERO_PAD, v};
      do @(posedge hclk); while (hready !== 1'b1);
      @(negedge hclk);
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] v);
      phase(a, 1'b0);
      do @(posedge hclk); while (hready !== 1'b1);
      // Data phase ends here; the flop still shows this cycle's word
      v = hrdata;
   endtask : rd
   task automatic t_regs;
      for (int i = 0; i < 4; i++) begin
         rd(12'(4 * i), d);
         chk(d, PABMX_ZERO_WORD);
      end
      wr(12'h020, 8'hFF);
      rd(12'h020, d);
      chk(d, PABMX_ZERO_WORD);
   endtask : t_regs
   task automatic unlock(input logic [7:0] p);
      for (int i = 7; i >= 0; i--) begin
         @(posedge hclk);
         reset_seq <= 1'b1;
         ext_a[0] <= p[i];
      end
      @(posedge hclk);
      reset_seq <= 1'b0;
      ext_a[0] <= 1'b1;
      repeat (3) @(negedge hclk);
   endtask : unlock
   task automatic t_debug;
      // Board holds the shared pin high so a plain input reads one
      ext_a <= 8'h01;
      @(negedge hclk);
      chk({debug_enable, gpio_a_in[0], port_a_oe[0]}, 3'b010);
      unlock(PABMX_UNLOCK_PATTERN);
      chk({debug_enable, gpio_a_in[0]}, 2'b10);
      rd(PABMX_OFF_STATUS, d);
      chk(d[PABMX_STS_DBG_BIT], 1'b1);
      unlock(8'h5A);
      chk({debug_enable, gpio_a_in[0]}, 2'b01);
   endtask : t_debug
   task automatic t_porta;
      @(posedge hclk);
      package_variant <= PABMX_PKG_20PIN;
      gpio_a_out <= 8'h0F;
      gpio_a_oe <= 8'hFF;
      @(negedge hclk);
      chk({port_a_oe, port_a_out}, 16'hFF0F);
      @(posedge hclk);
      gpio_a_oe <= 8'h00;
      ext_a <= 8'h19;
      wr(PABMX_OFF_PA_AF, 8'hFF);
      chk({port_a_out[7], port_a_out[5], port_a_out[2], port_a_out[1]}, 4'hB);
      chk({uart_clear_to_send, uart_receive_data, gpio_a_in}, 10'h3DF);
      chk({port_a_oe[0], timer_zero_input, port_a_oe[1]}, 3'b011);
      chk({port_a_oe[6], timer_one_input}, 2'b10);
      @(posedge hclk);
      timer0_in_mode <= 1'b0;
      @(negedge hclk);
      chk(port_a_oe[0], 1'b1);
      wr(PABMX_OFF_PA_AF, 8'h00);
   endtask : t_porta
   task automatic t_portb;
      @(posedge hclk);
      package_variant <= PABMX_PKG_28PIN;
      gpio_b_out <= 8'hFF;
      ext_b <= 8'h08;
      wr(PABMX_OFF_PB_SEL1, 8'h3F);
      wr(PABMX_OFF_PB_AF, 8'hFF);
      chk({port_b_analog_en[4:0], vref_on_port_b, external_clock_input}, 7'h7E);
      chk({analog_in0_amp_out, analog_in1_amp_inv, analog_in2_amp_noninv}, 3'h7);
      chk({analog_in3, analog_in7}, 2'h3);
      chk(port_b_oe, 8'h00);
      chk({gpio_b_in, port_b_out}, 16'h0000);
      wr(PABMX_OFF_PB_SEL2, 8'hFF);
      wr(PABMX_OFF_PB_SEL1, 8'h00);
      chk({port_b_analog_en[4:0], external_clock_input}, 6'h01);
      chk({analog_in3, analog_in7}, 2'h0);
      wr(PABMX_OFF_PB_AF, 8'h00);
      wr(PABMX_OFF_PB_SEL1, 8'h3F);
      chk({port_b_analog_en, vref_on_port_b}, 9'h000);
      chk({gpio_b_in, port_b_out}, 16'h08FF);
      @(posedge hclk);
      package_variant <= PABMX_PKG_20PIN;
      wr(PABMX_OFF_PB_AF, 8'hFF);
      chk(vref_on_port_b, 1'b0);
      chk({port_b_analog_en, vref_on_port_b}, 9'h03E);
   endtask : t_portb
   task automatic t_xtal;
      @(posedge hclk);
      gpio_a_oe <= 8'hFF;
      xtal_enable <= 1'b1;
      @(negedge hclk);
      chk({xtal_pins_en, gpio_a_in[1:0], port_a_oe[1:0]}, 5'h10);
      rd(PABMX_OFF_STATUS, d);
      chk(d[PABMX_STS_XTAL_BIT], 1'b1);
   endtask : t_xtal
   initial begin
      {hresetn, hwrite, reset_seq, xtal_enable, timer1_in_mode} = 5'h0;
      {hsel, timer0_in_mode, timer_zero_output, timer_one_output} = 4'hF;
      {uart_driver_enable, uart_transmit_data} = 2'b10;
      {htrans, haddr, hwdata, gpio_a_out, gpio_a_oe, gpio_b_out, gpio_b_oe} = '0;
      {ext_a, ext_b} = 16'h0000;
      hsize = 3'h2;
      package_variant = PABMX_PKG_8PIN;
      {failures, n_compared, cyc} = '0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_debug();
      t_porta();
      t_portb();
      t_xtal();
      report_and_stop();
   end
endmodule : test_port_ab_alternate_function_mux

// ==== verilog/pabmx_mux.sv ====
// Purpose: Alternate-function selection for ports A and B.
// Assumes: Package variant is a static strap; peripherals give their own directions.
// Notes: Port C/D selects are not held here; port A and D carry no set selects.
`timescale 1ns/10ps
module pabmx_mux
   import pabmx_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [1:0] package_variant,
   input wire logic reset_seq,
   input wire logic xtal_enable,
   input wire logic timer0_in_mode,
   input wire logic timer1_in_mode,
   input wire logic [7:0] gpio_a_out,
   input wire logic [7:0] gpio_a_oe,
   input wire logic [7:0] gpio_b_out,
   input wire logic [7:0] gpio_b_oe,
   input wire logic [7:0] port_a_in,
   input wire logic [7:0] port_b_in,
   output logic [7:0] port_a_out,
   output logic [7:0] port_a_oe,
   output logic [7:0] port_b_out,
   output logic [7:0] port_b_oe,
   output logic [7:0] port_b_analog_en,
   output logic [7:0] gpio_a_in,
   output logic [7:0] gpio_b_in,
   input wire logic timer_zero_output,
   input wire logic timer_one_output,
   input wire logic uart_driver_enable,
   input wire logic uart_transmit_data,
   output logic timer_zero_input,
   output logic timer_one_input,
   output logic uart_clear_to_send,
   output logic uart_receive_data,
   output logic external_clock_input,
   output logic analog_in0_amp_out,
   output logic analog_in1_amp_inv,
   output logic analog_in2_amp_noninv,
   output logic analog_in3,
   output logic analog_in7,
   output logic vref_on_port_b,
   output logic xtal_pins_en,
   output logic debug_enable
);
   typedef struct packed {
      logic [7:0] pa_af;
      logic [7:0] pb_af;
      logic [7:0] pb_sel1;
      logic [7:0] pb_sel2;
      logic [11:0] addr;
      logic wr;
      logic rd;
      logic [31:0] rdata;
   } pabmx_state_t;
   pabmx_state_t st_reg;
   pabmx_state_t st_next;
   logic unlocked;
   logic is_8pin;
   logic is_28pin;
   logic [7:0] a_af_eff;
   logic [7:0] a_alt_out;
   logic [7:0] a_alt_oe;
   logic [7:0] b_alt_oe;
   logic [7:0] a_ovr;
   logic [7:0] b_an;

   pabmx_unlock_watch u_watch (
      .hclk(hclk),
      .hresetn(hresetn),
      .reset_seq(reset_seq),
      .debug_pin(port_a_in[0]),
      .unlocked(unlocked)
   );

   // Bus side: decode in the address phase, act in the data phase
   always_comb begin
      st_next = st_reg;
      st_next.wr = 1'b0;
      st_next.rd = 1'b0;
      if (hsel && hready && htrans == PABMX_HTRANS_NONSEQ) begin
         st_next.addr = haddr[11:0];
         st_next.wr = hwrite;
         st_next.rd = !hwrite;
      end
      if (st_reg.wr) begin
         // Port A and D own no set-select words; those addresses read zero
         if (st_reg.addr == PABMX_OFF_PA_AF) begin
            st_next.pa_af = hwdata[7:0];
         end else if (st_reg.addr == PABMX_OFF_PB_AF) begin
            st_next.pb_af = hwdata[7:0];
         end else if (st_reg.addr == PABMX_OFF_PB_SEL1) begin
            st_next.pb_sel1 = hwdata[7:0];
         end else if (st_reg.addr == PABMX_OFF_PB_SEL2) begin
            st_next.pb_sel2 = hwdata[7:0];
         end
      end
      st_next.rdata = PABMX_ZERO_WORD;
      if (hsel && hready && htrans == PABMX_HTRANS_NONSEQ && !hwrite) begin
         if (haddr[11:0] == PABMX_OFF_PA_AF) begin
            st_next.rdata = {PABMX_ZERO_PAD, st_reg.pa_af};
         end else if (haddr[11:0] == PABMX_OFF_PB_AF) begin
            st_next.rdata = {PABMX_ZERO_PAD, st_reg.pb_af};
         end else if (haddr[11:0] == PABMX_OFF_PB_SEL1) begin
            st_next.rdata = {PABMX_ZERO_PAD, st_reg.pb_sel1};
         end else if (haddr[11:0] == PABMX_OFF_PB_SEL2) begin
            st_next.rdata = {PABMX_ZERO_PAD, st_reg.pb_sel2};
         end else if (haddr[11:0] == PABMX_OFF_STATUS) begin
            st_next.rdata = PABMX_ZERO_WORD;
            st_next.rdata[PABMX_STS_DBG_BIT] = debug_enable;
            st_next.rdata[PABMX_STS_XTAL_BIT] = xtal_enable;
            st_next.rdata[PABMX_STS_PKG_LSB +: 2] = package_variant;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign hrdata = st_reg.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   assign is_8pin = (package_variant == PABMX_PKG_8PIN);
   assign is_28pin = (package_variant == PABMX_PKG_28PIN);
   // Debug only exists on the 8-pin part; until unlocked bit 0 is a plain port pin
   assign debug_enable = is_8pin && unlocked;
   assign xtal_pins_en = xtal_enable;

   // Overrides win over any port setting
   always_comb begin
      a_ovr = 8'h00;
      if (xtal_enable) begin
         a_ovr[1:0] = 2'h3;
      end
      if (debug_enable) begin
         a_ovr[0] = 1'b1;
      end
   end

   // Enable alone connects the peripheral of each port A pin, and on the 8-pin part bit 1 also the clock input
   assign a_af_eff = st_reg.pa_af & ~a_ovr;
   always_comb begin
      a_alt_out = 8'h00;
      a_alt_oe = 8'h00;
      a_alt_out[0] = timer_zero_output;
      a_alt_oe[0] = !timer0_in_mode;
      a_alt_out[1] = timer_zero_output;
      a_alt_oe[1] = 1'b1;
      a_alt_out[2] = uart_driver_enable;
      a_alt_oe[2] = 1'b1;
      a_alt_out[5] = uart_transmit_data;
      a_alt_oe[5] = 1'b1;
      a_alt_out[6] = timer_one_output;
      a_alt_oe[6] = !timer1_in_mode;
      a_alt_out[7] = timer_one_output;
      a_alt_oe[7] = 1'b1;
   end

   // Peripheral decides direction once alternate function is chosen
   for (genvar i = 0; i < 8; i++) begin : g_pin_a
      always_comb begin
         if (a_af_eff[i]) begin
            port_a_out[i] = a_alt_out[i];
            port_a_oe[i] = a_alt_oe[i];
         end else if (a_ovr[i]) begin
            // Crystal or debug own the pad, so the port must not fight them
            port_a_out[i] = 1'b0;
            port_a_oe[i] = 1'b0;
         end else begin
            port_a_out[i] = gpio_a_out[i];
            port_a_oe[i] = gpio_a_oe[i];
         end
      end
   end
   // GPIO keeps seeing handed-over pins; only the overrides hide them
   assign gpio_a_in = port_a_in & ~a_ovr;

   // A peripheral input reads low unless its pin is handed over
   always_comb begin
      timer_zero_input = 1'b0;
      timer_one_input = 1'b0;
      uart_clear_to_send = 1'b0;
      uart_receive_data = 1'b0;
      // Timers pick input or a second copy of their output by their mode, not by a port setting
      if (a_af_eff[0] && timer0_in_mode) begin
         timer_zero_input = port_a_in[0];
      end
      if (a_af_eff[6] && timer1_in_mode) begin
         timer_one_input = port_a_in[6];
      end
      if (a_af_eff[3]) begin
         uart_clear_to_send = port_a_in[3];
      end
      if (a_af_eff[4]) begin
         uart_receive_data = port_a_in[4];
      end
   end

   // Select one only; enable must also be set
   assign b_an = st_reg.pb_af & st_reg.pb_sel1;
   always_comb begin
      port_b_analog_en = 8'h00;
      analog_in0_amp_out = 1'b0;
      analog_in1_amp_inv = 1'b0;
      analog_in2_amp_noninv = 1'b0;
      analog_in3 = 1'b0;
      analog_in7 = 1'b0;
      vref_on_port_b = 1'b0;
      if (b_an[0]) begin
         port_b_analog_en[0] = 1'b1;
         analog_in0_amp_out = 1'b1;
      end
      if (b_an[1]) begin
         port_b_analog_en[1] = 1'b1;
         analog_in1_amp_inv = 1'b1;
      end
      if (b_an[2]) begin
         port_b_analog_en[2] = 1'b1;
         analog_in2_amp_noninv = 1'b1;
      end
      if (b_an[3]) begin
         port_b_analog_en[3] = 1'b1;
         analog_in3 = 1'b1;
      end
      if (b_an[4]) begin
         port_b_analog_en[4] = 1'b1;
         analog_in7 = 1'b1;
      end
      // Smaller packages bring the reference out elsewhere, so the pad stays digital
      if (b_an[5] && is_28pin) begin
         port_b_analog_en[5] = 1'b1;
         vref_on_port_b = 1'b1;
      end
      // Bits 6 and 7 are reserved whatever the selects say
   end

   // Clock input pin depends on package
   always_comb begin
      external_clock_input = 1'b0;
      if (is_8pin) begin
         // The small package has no port B, so port A bit 1 takes the clock
         if (a_af_eff[1]) begin
            external_clock_input = port_a_in[1];
         end
      end else if (st_reg.pb_af[3] && !st_reg.pb_sel1[3]) begin
         external_clock_input = port_b_in[3];
      end
   end

   // Port B alternate functions are all inputs or analog: no drive while enabled
   assign b_alt_oe = 8'h00;
   for (genvar j = 0; j < 8; j++) begin : g_pin_b
      always_comb begin
         if (st_reg.pb_af[j]) begin
            port_b_out[j] = 1'b0;
            port_b_oe[j] = b_alt_oe[j];
            // An analog pad would read as noise, so GPIO sees zero
            gpio_b_in[j] = 1'b0;
         end else begin
            port_b_out[j] = gpio_b_out[j];
            port_b_oe[j] = gpio_b_oe[j];
            gpio_b_in[j] = port_b_in[j];
         end
      end
   end
endmodule : pabmx_mux

// ==== verilog/pabmx_unlock_watch.sv ====
// Purpose: Watches the shared debug pin while reset is applied.
// Assumes: The pin is sampled once per clock while the reset sequence runs.
// Notes: The verdict is latched at the end of the sequence and held until the next sequence starts.
`timescale 1ns/10ps
module pabmx_unlock_watch
   import pabmx_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic reset_seq,
   input wire logic debug_pin,
   output logic unlocked
);
   typedef struct packed {
      logic [7:0] shift;
      logic [3:0] cnt;
      logic unlocked;
   } pabmx_uw_t;
   pabmx_uw_t st_reg;
   pabmx_uw_t st_next;
   always_comb begin
      st_next = st_reg;
      if (reset_seq) begin
         // A fresh reset sequence clears the verdict; a sequence cut short leaves its count to the next
         st_next.shift = {st_reg.shift[6:0], debug_pin};
         if (st_reg.cnt != PABMX_UNLOCK_LEN) begin
            st_next.cnt = st_reg.cnt + 4'h1;
         end
         st_next.unlocked = 1'b0;
      end else if (st_reg.cnt == PABMX_UNLOCK_LEN) begin
         st_next.unlocked = (st_reg.shift == PABMX_UNLOCK_PATTERN);
         st_next.cnt = 4'h0;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign unlocked = st_reg.unlocked;
endmodule : pabmx_unlock_watch
